/* File: pmd_pkg.sv */
// Package for the protection map decoder: table layout, section codes,
// adder constants and the register port map.
// Assumes a single clock domain and a plain register port.
`default_nettype none
package pmd_pkg;
    // ------------------------------------------------------------------
    // Table geometry
    // ------------------------------------------------------------------
    localparam int          NUM_SECTIONS = 5;
    localparam int          SEC_BYTES    = 4;
    localparam int          TBL_BYTES    = NUM_SECTIONS * SEC_BYTES;
    localparam int          POS_W        = 10;
    localparam int          CNT_W        = 10;

    // Byte offsets within one section entry
    localparam logic [1:0]  FLD_TYPE     = 2'h0;
    localparam logic [1:0]  FLD_NSEC     = 2'h1;
    localparam logic [1:0]  FLD_START    = 2'h2;
    localparam logic [1:0]  FLD_END      = 2'h3;

    // ------------------------------------------------------------------
    // Sector types and their size descriptor locations
    // ------------------------------------------------------------------
    localparam logic [7:0]  TYPE_8K      = 8'h02;
    localparam logic [7:0]  TYPE_32K     = 8'h03;
    localparam logic [7:0]  TYPE_64K     = 8'h04;
    localparam logic [7:0]  DESC_LOC_8K  = 8'h4E;
    localparam logic [7:0]  DESC_LOC_32K = 8'h50;
    localparam logic [7:0]  DESC_LOC_64K = 8'h52;

    // Number-of-sectors exponents: four 8K blocks, one 32K block
    localparam logic [7:0]  NSEC_8K      = 8'h02;
    localparam logic [7:0]  NSEC_32K     = 8'h00;

    // Start and end adders (two's complement, 00 means bit zero)
    localparam logic [7:0]  ADD_ZERO     = 8'h00;
    localparam logic [7:0]  ADD_BOT_S    = 8'hFF;
    localparam logic [7:0]  ADD_BOT_E    = 8'h04;
    localparam logic [7:0]  ADD_LO32     = 8'hFD;
    localparam logic [7:0]  ADD_64_E     = 8'hFC;
    localparam logic [7:0]  ADD_HI32     = 8'hFE;
    localparam logic [7:0]  ADD_TOP_S    = 8'h07;
    localparam logic [7:0]  ADD_TOP_E    = 8'h0E;

    // ------------------------------------------------------------------
    // Density codes
    // ------------------------------------------------------------------
    localparam logic [3:0]  M_8MBIT      = 4'h4;
    localparam logic [3:0]  M_16MBIT     = 4'h5;
    localparam logic [3:0]  M_32MBIT     = 4'h6;
    localparam logic [3:0]  M_64MBIT     = 4'h7;
    localparam logic [3:0]  M_128MBIT    = 4'h8;

    typedef enum logic [2:0] {
        PMD_D8   = 3'h0,
        PMD_D16  = 3'h1,
        PMD_D32  = 3'h2,
        PMD_D64  = 3'h3,
        PMD_D128 = 3'h4
    } pmd_dens_t;

    // ------------------------------------------------------------------
    // Register port map (byte index into 8-bit registers)
    // ------------------------------------------------------------------
    localparam logic [7:0]  REG_TBL_BASE = 8'h00;
    localparam logic [7:0]  REG_DENSITY  = 8'h20;
    localparam logic [7:0]  REG_SEL      = 8'h21;
    localparam logic [7:0]  REG_FIRST_LO = 8'h22;
    localparam logic [7:0]  REG_FIRST_HI = 8'h23;
    localparam logic [7:0]  REG_LAST_LO  = 8'h24;
    localparam logic [7:0]  REG_LAST_HI  = 8'h25;
    localparam logic [7:0]  REG_CNT_LO   = 8'h26;
    localparam logic [7:0]  REG_CNT_HI   = 8'h27;
    localparam logic [7:0]  REG_STATUS   = 8'h28;
    localparam logic [7:0]  REG_BASE_KB  = 8'h29;
    localparam pmd_dens_t   DENS_RST     = PMD_D16;
    localparam logic [2:0]  SEL_RST      = 3'h0;
endpackage
`default_nettype wire

/* File: pmd_table_rom.sv */
// Parameter table image for the five protection sections.
// Purely combinational; the caller registers the byte it reads.
`default_nettype none
module pmd_table_rom (
    input  wire logic [4:0] idx,
    output logic      [7:0] data
);
    always_comb begin
        unique case (idx)
            5'd0:    data = pmd_pkg::TYPE_8K;
            5'd1:    data = pmd_pkg::NSEC_8K;
            5'd2:    data = pmd_pkg::ADD_BOT_S;
            5'd3:    data = pmd_pkg::ADD_BOT_E;
            5'd4:    data = pmd_pkg::TYPE_32K;
            5'd5:    data = pmd_pkg::NSEC_32K;
            5'd6:    data = pmd_pkg::ADD_LO32;
            5'd7:    data = pmd_pkg::ADD_LO32;
            5'd8:    data = pmd_pkg::TYPE_64K;
            5'd9:    data = pmd_pkg::ADD_ZERO;     // Count derives from density
            5'd10:   data = pmd_pkg::ADD_ZERO;
            5'd11:   data = pmd_pkg::ADD_64_E;
            5'd12:   data = pmd_pkg::TYPE_32K;
            5'd13:   data = pmd_pkg::NSEC_32K;
            5'd14:   data = pmd_pkg::ADD_HI32;
            5'd15:   data = pmd_pkg::ADD_HI32;
            5'd16:   data = pmd_pkg::TYPE_8K;
            5'd17:   data = pmd_pkg::NSEC_8K;
            5'd18:   data = pmd_pkg::ADD_TOP_S;
            5'd19:   data = pmd_pkg::ADD_TOP_E;
            default: data = 8'h00;
        endcase
    end
endmodule
`default_nettype wire

/* File: pmd_bit_calc.sv */
// Turns one stored adder into a protection-register bit position.
// Combinational; m is limited to the documented densities.
`default_nettype none
module pmd_bit_calc (
    input  wire logic [3:0]                   m,
    input  wire logic [7:0]                   adder,
    output logic      [pmd_pkg::POS_W-1:0]    pos
);
    logic [pmd_pkg::POS_W-1:0] base;
    logic [pmd_pkg::POS_W-1:0] ext;

    always_comb begin
        base = (pmd_pkg::POS_W'(1) << m) + pmd_pkg::POS_W'(1);
        ext  = {{(pmd_pkg::POS_W-8){adder[7]}}, adder};
        if (adder == pmd_pkg::ADD_ZERO) begin
            pos = '0;
        end else begin
            pos = base + ext;
        end
    end
endmodule
`default_nettype wire

/* File: pmd_top.sv */
// Protection map decoder: serves the section table, and decodes a chosen
// section into its bit range, sector count and base address.
// Assumes a host reading over a plain register port clocked by mclk.
`default_nettype none

// Functional notes
// - A start field of zero means protection bit zero, not an adder.
// - Bits advance by one per sector from start to end, spanning the sector count; the 8K sections span 6 and 8 bits for 4 sectors and set map_error.
// - The end field is an adder c giving a last bit of 2^m + 1 + c.
// - Layout is four 8K, one 32K, many 64K, one 32K, four 8K blocks, bottom up.
// - Type codes are 2 for 8K, 3 for 32K, 4 for 64K, described at 4E, 50, 52.
// - The 8K and 32K sector counts are two to the power of the stored byte n.
// - The 64K sector count is two to the power m, minus two.
// - The density code m is 4, 5, 6, 7, 8 for 8, 16, 32, 64, 128 Mbit.
// - Nonzero adders are signed two's-complement bytes.
// - The bottom 8K section stores start FF and end 04.
// - In 8K sections odd bits are read locks and even bits write locks.
// - The 32K sections store equal adders, FD for the lower, FE for the upper.
// - The 64K section stores start zero and end FC.
// - The top 8K section stores start 07 and end 0E.
module pmd_top (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            map_error,
    output logic      [7:0] lock_kind
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        pmd_pkg::pmd_dens_t          dens;
        logic [2:0]                  sel;
        logic [pmd_pkg::POS_W-1:0]   first;
        logic [pmd_pkg::POS_W-1:0]   last;
        logic [pmd_pkg::CNT_W-1:0]   count;
        logic [7:0]                  base_kb;
        logic                        mismatch;
        logic [7:0]                  kind;
        logic [7:0]                  rdata;
    } pmd_state_t;

    pmd_state_t s_q;
    pmd_state_t s_d;

    logic [3:0]                m_val;
    logic [4:0]                rom_idx;
    logic [4:0]                sec_base;
    logic [7:0]                rom_data;
    logic [7:0]                f_type;
    logic [7:0]                f_nsec;
    logic [7:0]                f_start;
    logic [7:0]                f_end;
    logic [pmd_pkg::POS_W-1:0] pos_start;
    logic [pmd_pkg::POS_W-1:0] pos_end;
    logic [pmd_pkg::CNT_W-1:0] cnt_calc;
    logic [pmd_pkg::POS_W-1:0] span;
    logic [7:0]                base_calc;
    logic [7:0]                kb_64;
    logic [7:0]                kind_bits;

    // ------------------------------------------------------------------
    // Density code
    // ------------------------------------------------------------------
    always_comb begin
        unique case (s_q.dens)
            pmd_pkg::PMD_D8:   m_val = pmd_pkg::M_8MBIT;
            pmd_pkg::PMD_D16:  m_val = pmd_pkg::M_16MBIT;
            pmd_pkg::PMD_D32:  m_val = pmd_pkg::M_32MBIT;
            pmd_pkg::PMD_D64:  m_val = pmd_pkg::M_64MBIT;
            pmd_pkg::PMD_D128: m_val = pmd_pkg::M_128MBIT;
            default:           m_val = pmd_pkg::M_16MBIT;
        endcase
    end

    // ------------------------------------------------------------------
    // Table image and per-section fields
    // ------------------------------------------------------------------
    // Host reads index the table directly; the decode path reads the
    // selected section's fields from the same constants.
    assign rom_idx  = reg_addr[4:0];
    assign sec_base = 5'(s_q.sel) * 5'(pmd_pkg::SEC_BYTES);

    pmd_table_rom u_rom (
        .idx  (rom_idx),
        .data (rom_data)
    );

    pmd_table_rom u_rom_type (
        .idx  (sec_base + 5'(pmd_pkg::FLD_TYPE)),
        .data (f_type)
    );

    pmd_table_rom u_rom_nsec (
        .idx  (sec_base + 5'(pmd_pkg::FLD_NSEC)),
        .data (f_nsec)
    );

    pmd_table_rom u_rom_start (
        .idx  (sec_base + 5'(pmd_pkg::FLD_START)),
        .data (f_start)
    );

    pmd_table_rom u_rom_end (
        .idx  (sec_base + 5'(pmd_pkg::FLD_END)),
        .data (f_end)
    );

    pmd_bit_calc u_calc_start (
        .m     (m_val),
        .adder (f_start),
        .pos   (pos_start)
    );

    pmd_bit_calc u_calc_end (
        .m     (m_val),
        .adder (f_end),
        .pos   (pos_end)
    );

    // Lock role of the first eight bits of an 8K section: odd positions read-lock
    for (genvar b = 0; b < 8; b++) begin : g_kind
        assign kind_bits[b] = (f_type == pmd_pkg::TYPE_8K) & (pos_start[0] ^ 1'(b % 2));
    end

    // ------------------------------------------------------------------
    // Decode of the selected section
    // ------------------------------------------------------------------
    always_comb begin
        kb_64 = 8'(((pmd_pkg::CNT_W'(1) << m_val) - pmd_pkg::CNT_W'(2)) * 64 / 32);
        if (f_type == pmd_pkg::TYPE_64K) begin
            cnt_calc = (pmd_pkg::CNT_W'(1) << m_val) - pmd_pkg::CNT_W'(2);
        end else begin
            cnt_calc = pmd_pkg::CNT_W'(1) << f_nsec[3:0];
        end
        span = pos_end - pos_start + pmd_pkg::POS_W'(1);
        // Base address in 32 KByte units, bottom-up section order
        unique case (s_q.sel)
            3'd0:    base_calc = 8'h00;
            3'd1:    base_calc = 8'h01;
            3'd2:    base_calc = 8'h02;
            3'd3:    base_calc = 8'h02 + kb_64;
            default: base_calc = 8'h03 + kb_64;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d          = s_q;
        s_d.first    = pos_start;
        s_d.last     = pos_end;
        s_d.count    = cnt_calc;
        s_d.base_kb  = base_calc;
        s_d.mismatch = (span != cnt_calc);
        s_d.kind     = kind_bits;
        if (reg_wr) begin
            if (reg_addr == pmd_pkg::REG_DENSITY) begin
                // Whole byte compared so a set high bit cannot alias a legal code
                if (reg_wdata <= 8'(pmd_pkg::PMD_D128)) begin
                    s_d.dens = pmd_pkg::pmd_dens_t'(reg_wdata[2:0]);
                end
            end else if (reg_addr == pmd_pkg::REG_SEL) begin
                if (reg_wdata < 8'(pmd_pkg::NUM_SECTIONS)) begin
                    s_d.sel = reg_wdata[2:0];
                end
            end
        end
        s_d.rdata = 8'h00;
        if (reg_rd) begin
            if (reg_addr < 8'(pmd_pkg::TBL_BYTES)) begin
                s_d.rdata = rom_data;
            end else begin
                unique case (reg_addr)
                    pmd_pkg::REG_DENSITY:  s_d.rdata = {5'h00, s_q.dens};
                    pmd_pkg::REG_SEL:      s_d.rdata = {5'h00, s_q.sel};
                    pmd_pkg::REG_FIRST_LO: s_d.rdata = s_q.first[7:0];
                    pmd_pkg::REG_FIRST_HI: s_d.rdata = 8'(s_q.first[pmd_pkg::POS_W-1:8]);
                    pmd_pkg::REG_LAST_LO:  s_d.rdata = s_q.last[7:0];
                    pmd_pkg::REG_LAST_HI:  s_d.rdata = 8'(s_q.last[pmd_pkg::POS_W-1:8]);
                    pmd_pkg::REG_CNT_LO:   s_d.rdata = s_q.count[7:0];
                    pmd_pkg::REG_CNT_HI:   s_d.rdata = 8'(s_q.count[pmd_pkg::CNT_W-1:8]);
                    pmd_pkg::REG_STATUS:   s_d.rdata = {7'h00, s_q.mismatch};
                    pmd_pkg::REG_BASE_KB:  s_d.rdata = s_q.base_kb;
                    default:               s_d.rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q          <= '0;
            s_q.dens     <= pmd_pkg::DENS_RST;
            s_q.sel      <= pmd_pkg::SEL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign map_error = s_q.mismatch;
    assign lock_kind = s_q.kind;
endmodule
`default_nettype wire

/* File: pmd_host_model.sv */
// Host-side model of the table reader: single-cycle register writes and reads.
// Assumes each task is entered just after a rising mclk edge.
`default_nettype none
module pmd_host_model (
    input  wire logic       mclk,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd} = 18'h00000;
    end
    // Idle address and data are inverted so a stale value is never trusted
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
        @(posedge mclk);
        {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge mclk);
        {reg_addr, reg_rd} <= {~a, 1'b0};
        #1 d = reg_rdata;
    endtask
    // Zero field is bit zero; otherwise a signed adder on 2^m + 1
    function automatic int pos(input int m, input int c);
        return (c == 0) ? 0 : (1 << m) + 1 + ((c > 127) ? c - 256 : c);
    endfunction
endmodule
`default_nettype wire

/* File: pmd_top_properties.sv */
// Port-level checks on the protection map decoder.
// Assumes one clock domain; bound to pmd_top below.
`default_nettype none
module pmd_top_properties (
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       map_error,
    input wire logic [7:0] lock_kind
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Decode outputs settle a few edges after reset; hold checks wait for that
    logic [2:0] age_q;
    always_ff @(posedge mclk) age_q <= sys_rst ? 3'h0 : (age_q == 3'h4 ? age_q : age_q + 3'h1);
    function automatic logic [7:0] exp_type(input logic [2:0] s);
        return (s == 3'h2) ? 8'h04 : (s == 3'h1 || s == 3'h3) ? 8'h03 : 8'h02;
    endfunction
    property p_type;
        reg_rd && reg_addr < 8'h14 && reg_addr[1:0] == 2'h0
        |=> reg_rdata == exp_type($past(reg_addr[4:2]));
    endproperty
    a_type: assert property (p_type) else $error("sector type byte wrong");
    property p_bot;
        reg_rd && reg_addr[7:1] == 7'h01 |=> reg_rdata == ($past(reg_addr[0]) ? 8'h04 : 8'hFF);
    endproperty
    a_bot: assert property (p_bot) else $error("bottom adder wrong");
    property p_mid;
        reg_rd && (reg_addr[7:1] == 7'h03 || reg_addr[7:1] == 7'h07)
        |=> reg_rdata == ($past(reg_addr[3]) ? 8'hFE : 8'hFD);
    endproperty
    a_mid: assert property (p_mid) else $error("32K adder wrong");
    property p_big;
        reg_rd && reg_addr[7:1] == 7'h05 |=> reg_rdata == ($past(reg_addr[0]) ? 8'hFC : 8'h00);
    endproperty
    a_big: assert property (p_big) else $error("64K adder wrong");
    property p_top;
        reg_rd && reg_addr[7:1] == 7'h09 |=> reg_rdata == ($past(reg_addr[0]) ? 8'h0E : 8'h07);
    endproperty
    a_top: assert property (p_top) else $error("top adder wrong");
    property p_stat;
        reg_rd && reg_addr == 8'h28 |=> reg_rdata == {7'h00, $past(map_error)};
    endproperty
    a_stat: assert property (p_stat) else $error("status differs from flag");
    property p_hold;
        age_q == 3'h4 && !$past(reg_wr) && !$past(reg_wr, 2) |-> $stable({map_error, lock_kind});
    endproperty
    a_hold: assert property (p_hold) else $error("decode moved without a write");
    property p_lock;
        lock_kind != 8'h00 |-> lock_kind == 8'h55 || lock_kind == 8'hAA;
    endproperty
    a_lock: assert property (p_lock) else $error("lock kinds do not alternate");
    c_err: cover property ($rose(map_error));
    c_lock: cover property (lock_kind != 8'h00);
    c_stat: cover property (reg_rd && reg_addr == 8'h28 ##1 reg_rdata[0]);
endmodule
bind pmd_top pmd_top_properties chk_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .map_error(map_error), .lock_kind(lock_kind));
`default_nettype wire

/* File: pmd_top_tb.sv */
// Self-checking bench for pmd_top against a behavioural section decoder.
// Assumes pmd_host_model drives the register port.
`default_nettype none
module pmd_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic       mclk;
    logic       sys_rst;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, lock_kind;
    logic       reg_wr, reg_rd, map_error;
    int         n_fail, checks_done, seed;
    int         ty[5] = '{2, 3, 4, 3, 2};
    int         ns[5] = '{2, 0, 0, 0, 2};
    int         st[5] = '{8'hFF, 8'hFD, 8'h00, 8'hFE, 8'h07};
    int         en[5] = '{8'h04, 8'hFD, 8'hFC, 8'hFE, 8'h0E};
    pmd_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .map_error(map_error),
        .lock_kind(lock_kind));
    pmd_host_model host_u (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", w, e, g);
            n_fail++;
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string w);
        logic [7:0] v;
        host_u.rd(a, v);
        chk(w, e, v);
    endtask
    task automatic dec(input int d, input int s);
        int m, f, l, c, b;
        logic [7:0] lk, mk;
        m = d + 4;
        f = host_u.pos(m, st[s]);
        l = host_u.pos(m, en[s]);
        c = (ty[s] == 4) ? (1 << m) - 2 : 1 << ns[s];
        host_u.wr(8'h20, 8'(d));
        host_u.wr(8'h21, 8'(s));
        rc(8'h22, 8'(f), "first lo");
        rc(8'h23, 8'(f >> 8), "first hi");
        rc(8'h24, 8'(l), "last lo");
        rc(8'h25, 8'(l >> 8), "last hi");
        rc(8'h26, 8'(c), "count lo");
        rc(8'h27, 8'(c >> 8), "count hi");
        rc(8'h28, {7'h00, (l - f + 1) != c}, "status");
        chk("map_error", {7'h00, (l - f + 1) != c}, {7'h00, map_error});
        rc(8'h29, 8'(s < 3 ? s : (2 << m) - 5 + s), "base");
        for (b = 0; b < 8; b++) begin
            mk[b] = (ty[s] != 2) || (b <= l - f);
            lk[b] = (ty[s] == 2) && (b <= l - f) && ((f + b) % 2 == 1);
        end
        chk("lock_kind", lk, lock_kind & mk);
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        n_fail++;
        end_of_test();
    end
    initial begin
        int i, d, s;
        n_fail = 0;
        checks_done = 0;
        seed = 26683;
        sys_rst = 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        rc(8'h20, 8'h01, "density at reset");
        rc(8'h21, 8'h00, "select at reset");
        d = host_u.pos(5, en[0]) - host_u.pos(5, st[0]) + 1;
        chk("map_error at reset", {7'h00, d != (1 << ns[0])}, {7'h00, map_error});
        for (i = 0; i < 20; i++) begin
            s = i / 4;
            d = (i % 4 == 0) ? ty[s] : (i % 4 == 1) ? ns[s] : (i % 4 == 2) ? st[s] : en[s];
            rc(8'(i), 8'(d), "table byte");
        end
        rc(8'h30, 8'h00, "unmapped read");
        for (d = 0; d < 5; d++) for (s = 0; s < 5; s++) dec(d, s);
        // Out-of-range codes and table writes must leave state alone
        host_u.wr(8'h20, 8'h05);
        host_u.wr(8'h21, 8'h05);
        host_u.wr(8'h02, 8'h00);
        host_u.wr(8'h20, 8'h08);
        host_u.wr(8'h21, 8'h0A);
        rc(8'h20, 8'h04, "density refused");
        rc(8'h21, 8'h04, "select refused");
        rc(8'h02, 8'hFF, "table write");
        for (i = 0; i < 20; i++) begin
            d = $random(seed);
            host_u.wr(8'h80 | 8'(d), 8'(d >> 8));
            dec({$random(seed)} % 5, {$random(seed)} % 5);
        end
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        chk("map_error in reset", 8'h00, {7'h00, map_error});
        rc(8'h20, 8'h01, "density after reset");
        rc(8'h21, 8'h00, "select after reset");
        end_of_test();
    end
endmodule
`default_nettype wire
